/* rtl/adcc_top.sv */
// adcc_top: conversion control of an on-chip successive-approximation
// converter: clock divider, start selection, tracking, flags, interrupt.
// assumes a register master on ref_clk; cmp_hi_pin and standby_pin come
// from outside the clock domain, timer_ovf from logic on ref_clk.
//
// Behaviour
// RULE1 - the conversion clock is the system clock divided by 1, 2, 4, 8 or 16 per the divide field.
// RULE2 - the two start-mode bits choose software writes or timer overflow as start source.
// RULE3 - in software mode writing a one to the in-progress bit starts a conversion.
// RULE4 - in timed mode each timer overflow starts a conversion.
// RULE5 - the in-progress bit reads one while a conversion runs and zero once it ends.
// RULE6 - the falling edge of the in-progress bit sets the done flag and, when enabled, requests an interrupt.
// RULE7 - software-start users should poll the done flag rather than the in-progress bit.
// RULE8 - each finished result is placed in the result register for software to read.
// RULE9 - with track mode at zero the input is tracked at all times except during conversion.
// RULE10 - with track mode at one a low-power track-and-hold is used, variant picked by start mode.
// RULE11 - low-power software mode tracks for three conversion clocks after the start write.
// RULE12 - low-power timed mode tracks for three conversion clocks after the overflow.
// RULE13 - a conversion ends within sixteen conversion clocks after tracking ends.
// RULE14 - tracking may be shut down while the chip is in standby or sleep.
// RULE15 - software keeps the request rate at or below 100 ksps.
// RULE16 - the end-of-conversion request passes only while its enable bit is one.
// RULE17 - a start arriving during a conversion is ignored and does not restart it.
`timescale 1ns/1ps
`default_nettype none
module adcc_top
   import adcc_pkg::*;
#(
   parameter int RES_W = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // register port
   input wire logic [REG_AW-1:0] reg_addr,
   input wire logic [REG_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [REG_DW-1:0] reg_rdata,
   // start sources and power state
   input wire logic timer_ovf,
   input wire logic standby_pin,
   // analogue front end
   input wire logic cmp_hi_pin,
   output logic track_en,
   output logic [RES_W-1:0] dac_code,
   // interrupt
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////
   // elaboration check
   if (RES_W < 1 || RES_W > REG_DW) begin : g_bad_res
      $error("adcc_top: RES_W must lie between 1 and the register width");
   end

   ////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic [3:0] div_limit(input logic [2:0] sel);
      logic [3:0] lim;
      lim = DIV_LIM_16;
      unique case (sel)
         3'h0: lim = DIV_LIM_1;
         3'h1: lim = DIV_LIM_2;
         3'h2: lim = DIV_LIM_4;
         3'h3: lim = DIV_LIM_8;
         default: lim = DIV_LIM_16;
      endcase
      return lim;
   endfunction : div_limit

   function automatic logic wr_hit(input logic wr, input logic [7:0] a,
                                   input logic [7:0] target);
      return wr && (a == target);
   endfunction : wr_hit

   ////////////////////////////////////////////////////////////////////////
   // state
   logic [3:0] cfg_q;
   logic [1:0] mode_q;
   logic track_mode_q;
   logic done_flag_q;
   logic eoc_en_q;
   logic [IRQ_W-1:0] irq_stat_q;
   logic [IRQ_W-1:0] irq_stat_d;
   logic [IRQ_W-1:0] irq_mask_q;
   logic [3:0] div_cnt_q;
   logic busy_prev_q;
   logic [RES_W-1:0] result_q;
   logic [REG_DW-1:0] rdata_q;
   logic cmp_meta_q;
   logic cmp_sync_q;
   logic stby_meta_q;
   logic stby_sync_q;

   // sequencer wires
   logic sar_tick;
   logic seq_busy;
   logic seq_tracking;
   logic seq_done;
   logic [RES_W-1:0] seq_result;

   // decode
   logic ctl_wr;
   logic sw_start;
   logic tmr_start;
   logic start_req;
   logic start_go;
   logic overrun;
   logic busy_fall;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cmp_meta_q <= 1'b0;
         cmp_sync_q <= 1'b0;
      end else begin
         cmp_meta_q <= cmp_hi_pin;
         cmp_sync_q <= cmp_meta_q;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         stby_meta_q <= 1'b0;
         stby_sync_q <= 1'b0;
      end else begin
         stby_meta_q <= standby_pin;
         stby_sync_q <= stby_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // conversion clock divider; held at zero while idle so the first
   // conversion clock always falls a full period after the start
   assign sar_tick = seq_busy &&
                     (div_cnt_q == div_limit(cfg_q[CFG_DIV_LSB +: CFG_DIV_W]));

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_cnt_q <= 4'h0;
      end else if (!seq_busy || sar_tick) begin // RULE1
         div_cnt_q <= 4'h0;
      end else begin
         div_cnt_q <= div_cnt_q + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // start selection
   assign ctl_wr = wr_hit(reg_wr, reg_addr, ADDR_CONTROL);
   // reserved mode codes start nothing
   assign sw_start = ctl_wr && reg_wdata[CTL_BUSY_BIT] &&
                     (mode_q == MODE_SOFTWARE); // RULE2 RULE3
   assign tmr_start = timer_ovf && (mode_q == MODE_TIMER); // RULE2 RULE4
   assign start_req = sw_start || tmr_start;
   assign start_go = start_req && !seq_busy; // RULE17
   assign overrun = start_req && seq_busy; // RULE17

   adcc_sar_seq #(
      .RES_W(RES_W)
   ) u_seq (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .sar_tick(sar_tick),
      .start(start_go),
      .lp_track(track_mode_q), // RULE10
      .cmp_hi(cmp_sync_q),
      .busy(seq_busy),
      .tracking(seq_tracking),
      .done(seq_done),
      .dac_code(dac_code),
      .result(seq_result)
   );

   ////////////////////////////////////////////////////////////////////////
   // tracking: continuous outside conversion, or the short low-power
   // window; standby may cut it when software allows
   always_comb begin
      if (cfg_q[CFG_SHUTDOWN_BIT] && stby_sync_q) begin
         track_en = 1'b0; // RULE14
      end else if (track_mode_q) begin
         track_en = seq_tracking; // RULE10 RULE11 RULE12
      end else begin
         track_en = !seq_busy; // RULE9
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_q <= CFG_RESET;
      end else if (wr_hit(reg_wr, reg_addr, ADDR_CONFIG)) begin
         cfg_q <= reg_wdata[3:0];
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_q <= CTL_MODE_RESET;
         track_mode_q <= 1'b0;
      end else if (ctl_wr) begin
         mode_q <= {reg_wdata[CTL_MODE_HI_BIT], reg_wdata[CTL_MODE_LO_BIT]};
         track_mode_q <= reg_wdata[CTL_TRACK_MODE_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         eoc_en_q <= 1'b0;
      end else if (wr_hit(reg_wr, reg_addr, ADDR_EXT_IRQ_EN2)) begin
         eoc_en_q <= reg_wdata[EXTENDED_IRQ_ENABLE_TWO_EOC_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_mask_q <= IRQ_RESET;
      end else if (wr_hit(reg_wr, reg_addr, ADDR_IRQ_MASK)) begin
         irq_mask_q <= reg_wdata[IRQ_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // done flag and result
   assign busy_fall = busy_prev_q && !seq_busy;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_prev_q <= 1'b0;
      end else begin
         busy_prev_q <= seq_busy;
      end
   end

   // writing zero clears the flag; a finishing conversion in the same
   // cycle wins so no completion is lost
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         done_flag_q <= 1'b0;
      end else if (busy_fall) begin
         done_flag_q <= 1'b1; // RULE6
      end else if (ctl_wr && !reg_wdata[CTL_DONE_BIT]) begin
         done_flag_q <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         result_q <= '0;
      end else if (seq_done) begin
         result_q <= seq_result; // RULE8
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // interrupt status: write one to clear, set wins
   always_comb begin
      irq_stat_d = irq_stat_q;
      if (wr_hit(reg_wr, reg_addr, ADDR_IRQ_STATUS)) begin
         irq_stat_d = irq_stat_q & ~reg_wdata[IRQ_W-1:0];
      end
      if (busy_fall) begin
         irq_stat_d[IRQ_DONE_BIT] = 1'b1; // RULE6
      end
      if (overrun) begin
         irq_stat_d[IRQ_OVERRUN_BIT] = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq_stat_q <= IRQ_RESET;
      end else begin
         irq_stat_q <= irq_stat_d;
      end
   end

   // the done request also needs its enable bit, so either the mask or
   // the enable can silence it
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         irq <= 1'b0;
      end else begin
         irq <= (irq_stat_q[IRQ_DONE_BIT] && irq_mask_q[IRQ_DONE_BIT] &&
                 eoc_en_q) || // RULE16 RULE6
                (irq_stat_q[IRQ_OVERRUN_BIT] &&
                 irq_mask_q[IRQ_OVERRUN_BIT]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read port: data one cycle after the strobe, zero elsewhere
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            ADDR_CONFIG: begin
               rdata_q <= {4'h0, cfg_q};
            end
            ADDR_CONTROL: begin
               rdata_q <= {1'b0, track_mode_q, done_flag_q,
                           seq_busy, mode_q, 2'h0}; // RULE5
            end
            ADDR_RESULT_HI: begin
               rdata_q <= REG_DW'(result_q); // RULE8
            end
            ADDR_EXT_IRQ_EN2: begin
               rdata_q <= {6'h00, eoc_en_q, 1'b0};
            end
            ADDR_IRQ_STATUS: begin
               rdata_q <= {6'h00, irq_stat_q};
            end
            ADDR_IRQ_MASK: begin
               rdata_q <= {6'h00, irq_mask_q};
            end
            default: begin
               rdata_q <= 8'h00;
            end
         endcase
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata = rdata_q;

endmodule : adcc_top
`default_nettype wire

/* rtl/adcc_pkg.sv */
// adcc_pkg: shared constants and types of the converter control block.
// assumes an 8-bit register port; offsets are indexes on that port.
package adcc_pkg;

   // register port widths
   localparam int REG_AW = 8;
   localparam int REG_DW = 8;

   // register offsets
   localparam logic [7:0] ADDR_CONFIG = 8'h00;
   localparam logic [7:0] ADDR_CONTROL = 8'h01;
   localparam logic [7:0] ADDR_RESULT_HI = 8'h02;
   localparam logic [7:0] ADDR_EXT_IRQ_EN2 = 8'h03;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h04;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h05;

   // converter_config_reg fields
   localparam int CFG_DIV_LSB = 0;
   localparam int CFG_DIV_W = 3;
   localparam int CFG_SHUTDOWN_BIT = 3;
   localparam logic [3:0] CFG_RESET = 4'h0;

   // converter_control_reg fields
   localparam int CTL_MODE_LO_BIT = 2;
   localparam int CTL_MODE_HI_BIT = 3;
   localparam int CTL_BUSY_BIT = 4;
   localparam int CTL_DONE_BIT = 5;
   localparam int CTL_TRACK_MODE_BIT = 6;
   localparam logic [1:0] CTL_MODE_RESET = 2'h0;

   // extended_irq_enable_two fields
   localparam int EXTENDED_IRQ_ENABLE_TWO_EOC_BIT = 1;

   // interrupt status and mask layout
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_OVERRUN_BIT = 1;
   localparam int IRQ_W = 2;
   localparam logic [1:0] IRQ_RESET = 2'h0;

   // start-mode encodings {hi, lo}
   localparam logic [1:0] MODE_SOFTWARE = 2'h0;
   localparam logic [1:0] MODE_TIMER = 2'h1;

   // sequence lengths in conversion clocks
   localparam int TRACK_SAR_CLKS = 3;
   localparam int CONV_SAR_CLKS = 16;

   // divider terminal counts for divide 1, 2, 4, 8, 16
   localparam logic [3:0] DIV_LIM_1 = 4'h0;
   localparam logic [3:0] DIV_LIM_2 = 4'h1;
   localparam logic [3:0] DIV_LIM_4 = 4'h3;
   localparam logic [3:0] DIV_LIM_8 = 4'h7;
   localparam logic [3:0] DIV_LIM_16 = 4'hF;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_TRACK = 2'b01,
      ST_CONV = 2'b10
   } adcc_seq_t;

endpackage : adcc_pkg

/* rtl/adcc_sar_seq.sv */
// adcc_sar_seq: track and successive-approximation sequencer.
// assumes sar_tick is a one-cycle pulse per conversion clock and that
// cmp_hi is already synchronised to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module adcc_sar_seq
   import adcc_pkg::*;
#(
   parameter int RES_W = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // control
   input wire logic sar_tick,
   input wire logic start,
   input wire logic lp_track,
   input wire logic cmp_hi,
   // status and data
   output logic busy,
   output logic tracking,
   output logic done,
   output logic [RES_W-1:0] dac_code,
   output logic [RES_W-1:0] result
);

   adcc_seq_t state_q;
   logic [4:0] cnt_q;
   logic [RES_W-1:0] trial_q;
   logic last_tick;

   assign last_tick = sar_tick && (cnt_q == 5'(CONV_SAR_CLKS - 1));

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_IDLE;
         cnt_q <= 5'h00;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (start) begin
                  state_q <= lp_track ? ST_TRACK : ST_CONV; // RULE11 RULE12
                  cnt_q <= 5'h00;
               end
            end
            ST_TRACK: begin
               if (sar_tick) begin
                  if (cnt_q == 5'(TRACK_SAR_CLKS - 1)) begin // RULE11 RULE12
                     state_q <= ST_CONV;
                     cnt_q <= 5'h00;
                  end else begin
                     cnt_q <= cnt_q + 5'h01;
                  end
               end
            end
            ST_CONV: begin
               if (last_tick) begin // RULE13
                  state_q <= ST_IDLE;
               end else if (sar_tick) begin
                  cnt_q <= cnt_q + 5'h01;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               cnt_q <= 5'h00;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // one bit decided per conversion clock, msb first; the remaining
   // clocks of the sixteen give the analogue side settling margin
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         trial_q <= {1'b1, {(RES_W-1){1'b0}}};
      end else if (state_q != ST_CONV) begin
         trial_q <= {1'b1, {(RES_W-1){1'b0}}};
      end else if (sar_tick && (int'(cnt_q) < RES_W)) begin
         for (int i = 0; i < RES_W; i++) begin
            if (i == RES_W - 1 - int'(cnt_q)) begin
               if (!cmp_hi) begin
                  trial_q[i] <= 1'b0;
               end
            end
            if (i + 1 == RES_W - 1 - int'(cnt_q)) begin
               trial_q[i] <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         result <= '0;
         done <= 1'b0;
      end else begin
         done <= (state_q == ST_CONV) && last_tick;
         if ((state_q == ST_CONV) && last_tick) begin
            result <= trial_q;
         end
      end
   end

   assign busy = (state_q != ST_IDLE);
   assign tracking = (state_q == ST_TRACK);
   assign dac_code = trial_q;

endmodule : adcc_sar_seq
`default_nettype wire

/* tb/adcc_top_props.sv */
// adcc_top_props: port-level checker of the converter control block.
// assumes binding into adcc_top; it shadows register writes by itself.
`timescale 1ns/1ps
`default_nettype none
module adcc_top_props
   import adcc_pkg::*;
#(
   parameter int RES_W = 8
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic arst_n,
   // register port
   input wire logic [REG_AW-1:0] reg_addr,
   input wire logic [REG_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [REG_DW-1:0] reg_rdata,
   // start sources and front end
   input wire logic timer_ovf,
   input wire logic standby_pin,
   input wire logic cmp_hi_pin,
   input wire logic track_en,
   input wire logic [RES_W-1:0] dac_code,
   input wire logic irq
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!arst_n);

   ////////////////////////////////////////////////////////////////////////
   logic [3:0] cfg_q;
   logic [6:2] ctl_q;
   logic en_q;
   logic mask_q;
   logic [9:0] lo_cnt_q;
   logic [9:0] div;
   logic sw_go;
   logic tm_go;
   logic idle;
   assign div = (cfg_q[2:0] > 3'h4) ? 10'h010 : (10'h001 << cfg_q[2:0]);
   assign sw_go = reg_wr && reg_addr == ADDR_CONTROL && reg_wdata[4]
      && reg_wdata[3:2] == MODE_SOFTWARE && ctl_q[3:2] == MODE_SOFTWARE;
   assign tm_go = timer_ovf && ctl_q[3:2] == MODE_TIMER;
   // busy shows on track_en only in full-power mode with no shutdown
   assign idle = track_en && !ctl_q[6] && !cfg_q[3];

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_q <= CFG_RESET;
         ctl_q <= 5'h00;
         en_q <= 1'b0;
         mask_q <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_CONFIG) cfg_q <= reg_wdata[3:0];
         if (reg_addr == ADDR_CONTROL) ctl_q <= reg_wdata[6:2];
         if (reg_addr == ADDR_EXT_IRQ_EN2) en_q <= reg_wdata[EXTENDED_IRQ_ENABLE_TWO_EOC_BIT];
         if (reg_addr == ADDR_IRQ_MASK) mask_q <= reg_wdata[IRQ_DONE_BIT];
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) lo_cnt_q <= 10'h000;
      else if (track_en) lo_cnt_q <= 10'h000;
      else lo_cnt_q <= lo_cnt_q + 10'h001;
   end

   ////////////////////////////////////////////////////////////////////////
   rd_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
      else $error("read data not zero outside a read");
   sw_start_a: assert property (
      idle && sw_go && !reg_wdata[6] |=> !track_en)
      else $error("software start did not begin a conversion");
   mode_sel_a: assert property (
      idle && reg_wr && reg_addr == ADDR_CONTROL && reg_wdata[3]
      && ctl_q[3] && !reg_wdata[6] |=> track_en)
      else $error("reserved start mode began a conversion");
   timer_start_a: assert property (idle && tm_go |=> !track_en)
      else $error("timer overflow did not begin a conversion");
   conv_len_a: assert property (
      $rose(track_en) && !$past(ctl_q[6]) && !ctl_q[6] && !cfg_q[3]
      |-> lo_cnt_q == div * 10'h010)
      else $error("conversion length wrong");
   lp_track_a: assert property (
      $rose(track_en) && ctl_q[6] && cfg_q[2:0] == 3'h0
      |-> track_en [*3] ##1 !track_en)
      else $error("low-power tracking not three conversion clocks");
   done_irq_a: assert property (
      $rose(track_en) && !$past(ctl_q[6]) && !ctl_q[6] && !cfg_q[3]
      && en_q && mask_q |-> ##2 irq)
      else $error("end of conversion raised no interrupt");
   irq_mask_a: assert property (!(en_q && mask_q) |=> !irq)
      else $error("interrupt passed while disabled");
   track_idle_a: assert property (
      $fell(track_en) && !ctl_q[6] && !cfg_q[3] |-> $past(sw_go || tm_go))
      else $error("tracking stopped without a start");
endmodule : adcc_top_props

bind adcc_top adcc_top_props #(.RES_W(RES_W)) u_adcc_top_props (
   .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .timer_ovf(timer_ovf), .standby_pin(standby_pin),
   .cmp_hi_pin(cmp_hi_pin), .track_en(track_en), .dac_code(dac_code),
   .irq(irq)
);
`default_nettype wire

/* tb/adcc_top_tb.sv */
// adcc_top_tb: self-checking bench of the converter control block.
// assumes the checker is bound in its own file; drives every input.
`timescale 1ns/1ps
`default_nettype none
module adcc_top_tb
   import adcc_pkg::*;
;
   typedef struct packed {
      logic [2:0] div;
      logic tm;
      logic cmp;
   } adcc_row_t;
   adcc_row_t rows [8];
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   logic [REG_AW-1:0] reg_addr = 8'h00;
   logic [REG_DW-1:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [REG_DW-1:0] reg_rdata;
   logic timer_ovf = 1'b0;
   logic standby_pin = 1'b0;
   logic cmp_hi_pin = 1'b0;
   logic track_en;
   logic [7:0] dac_code;
   logic irq;
   logic [7:0] rv;
   logic [7:0] ra [6] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h07};
   logic [7:0] rm [6] = '{8'h0F, 8'h7C, 8'h02, 8'h03, 8'h03, 8'hFF};
   int bad_count = 0;
   int cmp_count = 0;
   int n;

   always #4 ref_clk = ~ref_clk;

   adcc_top u_adcc_top (
      .ref_clk(ref_clk), .arst_n(arst_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .timer_ovf(timer_ovf),
      .standby_pin(standby_pin), .cmp_hi_pin(cmp_hi_pin),
      .track_en(track_en), .dac_code(dac_code), .irq(irq)
   );

   ////////////////////////////////////////////////////////////////////////
   task automatic print_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : print_verdict

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected register at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk_reg

   task automatic chk_pin(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected pin at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : chk_pin

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask : wr

   // read data stand only in the cycle after the strobe, so sample there
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      rv = reg_rdata;
   endtask : rd

   task automatic pulse_ovf;
      @(posedge ref_clk);
      timer_ovf <= 1'b1;
      @(posedge ref_clk);
      timer_ovf <= 1'b0;
   endtask : pulse_ovf

   task automatic wait_done;
      n = 0;
      rv = 8'h00;
      while (rv[CTL_DONE_BIT] !== 1'b1) begin
         if (n++ > 400) begin
            bad_count++;
            print_verdict();
         end
         rd(ADDR_CONTROL);
      end
   endtask : wait_done

   ////////////////////////////////////////////////////////////////////////
   initial begin
      rows = '{'{3'h0, 1'b0, 1'b1}, '{3'h1, 1'b0, 1'b0}, '{3'h2, 1'b0, 1'b1},
         '{3'h3, 1'b0, 1'b0}, '{3'h4, 1'b0, 1'b1}, '{3'h7, 1'b0, 1'b0},
         '{3'h2, 1'b1, 1'b1}, '{3'h0, 1'b1, 1'b0}};
      repeat (12) @(posedge ref_clk);
      arst_n <= 1'b1;
      wr(ADDR_EXT_IRQ_EN2, 8'h02);
      wr(ADDR_IRQ_MASK, 8'h01);
      for (int i = 0; i < 8; i++) begin
         @(posedge ref_clk);
         cmp_hi_pin <= rows[i].cmp;
         wr(ADDR_CONFIG, {5'h00, rows[i].div});
         // the start write sees the track mode already held, so set it first
         wr(ADDR_CONTROL, {1'b0, rows[i].tm, 6'h00});
         wr(ADDR_CONTROL, {1'b0, rows[i].tm, 6'h10});
         rd(ADDR_CONTROL);
         chk_reg(rv & 8'h10, 8'h10);
         wait_done();
         chk_reg(rv & 8'h70, {1'b0, rows[i].tm, 6'h20});
         rd(ADDR_RESULT_HI);
         chk_reg(rv, rows[i].cmp ? 8'hFF : 8'h00);
         chk_pin(irq, 1'b1);
         wr(ADDR_IRQ_STATUS, 8'h01);
         wr(ADDR_CONTROL, {1'b0, rows[i].tm, 6'h00});
         #1;
         chk_pin(irq, 1'b0);
         $display("row %0d done", i);
      end
      // a second start while busy must neither restart nor be lost silently
      wr(ADDR_CONFIG, 8'h00);
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_CONTROL, 8'h10);
      wr(ADDR_CONTROL, 8'h10);
      wait_done();
      rd(ADDR_IRQ_STATUS);
      chk_reg(rv, 8'h03);
      wr(ADDR_IRQ_STATUS, 8'h03);
      $display("restart test done");
      wr(ADDR_CONTROL, 8'h04);
      wr(ADDR_CONTROL, 8'h14);
      rd(ADDR_CONTROL);
      chk_reg(rv & 8'h10, 8'h00);
      pulse_ovf();
      rd(ADDR_CONTROL);
      chk_reg(rv & 8'h10, 8'h10);
      wait_done();
      wr(ADDR_CONTROL, 8'h08);
      wr(ADDR_CONTROL, 8'h18);
      pulse_ovf();
      rd(ADDR_CONTROL);
      chk_reg(rv & 8'h30, 8'h00);
      $display("start mode test done");
      wr(ADDR_CONFIG, 8'h01);
      wr(ADDR_CONTROL, 8'h44);
      pulse_ovf();
      n = 0;
      repeat (40) begin
         #1;
         if (track_en === 1'b1) n++;
         @(posedge ref_clk);
      end
      chk_reg(8'(n), 8'h06);
      wait_done();
      $display("low-power timed test done");
      chk_pin(irq, 1'b1);
      wr(ADDR_IRQ_MASK, 8'h00);
      // irq is registered, so it follows one edge after the write lands
      @(posedge ref_clk);
      #1;
      chk_pin(irq, 1'b0);
      wr(ADDR_IRQ_MASK, 8'h01);
      wr(ADDR_EXT_IRQ_EN2, 8'h00);
      @(posedge ref_clk);
      #1;
      chk_pin(irq, 1'b0);
      wr(ADDR_EXT_IRQ_EN2, 8'h02);
      @(posedge ref_clk);
      #1;
      chk_pin(irq, 1'b1);
      wr(ADDR_IRQ_STATUS, 8'h01);
      wr(ADDR_CONTROL, 8'h40);
      rd(ADDR_CONTROL);
      chk_reg(rv & 8'h20, 8'h00);
      chk_pin(irq, 1'b0);
      $display("interrupt test done");
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_CONFIG, 8'h0B);
      @(posedge ref_clk);
      standby_pin <= 1'b1;
      repeat (6) @(posedge ref_clk);
      #1;
      chk_pin(track_en, 1'b0);
      standby_pin <= 1'b0;
      repeat (6) @(posedge ref_clk);
      #1;
      chk_pin(track_en, 1'b1);
      $display("standby test done");
      @(posedge ref_clk);
      arst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      arst_n <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rd(ra[i]);
         chk_reg(rv & rm[i], 8'h00);
      end
      chk_pin(track_en, 1'b1);
      chk_pin(irq, 1'b0);
      chk_reg(dac_code, 8'h80);
      $display("reset test done");
      print_verdict();
   end
endmodule : adcc_top_tb
`default_nettype wire
